// ==== src/adc_seq_consts.svh ====
// Purpose: offsets, field values, reset values and timing counts
// Assumes: byte addresses on a 32-bit AHB-Lite register bus
// Notes: definitions only
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
// register byte offsets
`define A_MODE 8'h00
`define A_SEQ 8'h04
`define A_BUFM 8'h08
`define A_CFG 8'h0C
`define A_STAT 8'h10
`define A_ACC0 8'h14
`define A_ACC1 8'h18
`define A_FLO 8'h1C
`define A_FHI 8'h20
`define A_BUF_HI 2'h1
// sequence control bits
`define SEQUENCE_START_BIT_BIT 0
`define SEQUENCE_ABORT_BIT_BIT 1
// operating_mode_select codes
`define M_MAN_A 3'h0
`define M_MAN_B 3'h1
`define M_SCAN_A 3'h4
`define M_SCAN_B 3'h5
`define M_AUTO 3'h6
`define M_PREC 3'h7
// buffer_fill_mode codes
`define BF_STOP 3'h0
`define BF_START 3'h1
`define BF_PRE 3'h4
`define BF_POST 3'h6
// reset values
`define MODE_RST 3'h0
`define BUFM_RST 3'h0
`define SCAN_RST 2'h3
`define DIV_RST 8'h00
// buffer and accumulation sizes
`define BUF_DEPTH 16
`define ACC_RUNS 5'h10
// timing: clock period and least scl low time before release in ns, and that low time in clocks
`define CLK_NS 25
`define STRETCH_NS 1800
`define STRETCH_CYC ((`STRETCH_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== src/adc_seq_pkg.sv ====
// Purpose: types shared by the sequencer and its sample store
// Assumes: nothing
// Notes: constants live in adc_seq_consts.svh
package adc_seq_pkg;
  typedef logic [11:0] sample_t;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_man = 5'h02,
    st_auto = 5'h04,
    st_prec = 5'h08,
    st_halt = 5'h10
  } seq_state_t;
endpackage : adc_seq_pkg

// ==== src/store_if.sv ====
// Purpose: carrier between the sequencer and its sample store
// Assumes: one clock
// Notes: ctl drives writes and the read index, mem answers
`timescale 1ns/1ps
interface store_if;
  logic wr_en;
  adc_seq_pkg::sample_t wr_data;
  logic clr;
  logic [3:0] rd_idx;
  adc_seq_pkg::sample_t rd_data;
  logic [4:0] count;
  logic full;
  modport ctl (output wr_en, wr_data, clr, rd_idx,
               input rd_data, count, full);
  modport mem (input wr_en, wr_data, clr, rd_idx,
               output rd_data, count, full);
endinterface : store_if

// ==== src/sample_store.sv ====
// Purpose: 16-entry circular result buffer
// Assumes: wr_en and clr are one-cycle strobes
// Notes: once full, new results overwrite the oldest entries
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module sample_store (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  store_if.mem sif // write and read side
);
  adc_seq_pkg::sample_t mem_q [`BUF_DEPTH];
  logic [3:0] wptr_q;
  logic [4:0] cnt_q;

  // write pointer wraps, count saturates at depth
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_q <= 4'h0;
      cnt_q <= 5'h00;
    end else if (sif.clr) begin
      wptr_q <= 4'h0;
      cnt_q <= 5'h00;
    end else if (sif.wr_en) begin
      wptr_q <= wptr_q + 4'h1;
      if (!sif.full) cnt_q <= cnt_q + 5'h01;
    end
  end

  // storage cells
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `BUF_DEPTH; i++) mem_q[i] <= 12'h000;
    end else if (sif.wr_en && !sif.clr) begin
      mem_q[wptr_q] <= sif.wr_data;
    end
  end

  // status and read port
  assign sif.rd_data = mem_q[sif.rd_idx];
  assign sif.count = cnt_q;
  assign sif.full = (cnt_q == 5'(`BUF_DEPTH));
endmodule : sample_store

// ==== src/adc_mode_sequencer.sv ====
// Purpose: mode sequencer of a two-channel monitoring converter
// Assumes: i2c and converter strobes come from logic on clk
// Notes: registers on AHB-Lite, zero wait states, always OKAY
// Overview of operation
// (R01) modes 000b/001b: manual, converting channel zero only
// (R02) manual single: address+read starts, conversions follow scl clocks
// (R03) host ends single manual with nack and stop, then changes mode
// (R04) modes 100b/101b: manual scan, needs start bit then address+read
// (R05) host sets abort bit before leaving manual scan
// (R06) any register read aborts the manual scan
// (R07) manual mode uses fast oscillator and ignores the divider
// (R08) manual rate is 1000 / (18 scl periods + k) kSPS
// (R09) scl low under 1.8 us is stretched to 1.8 us
// (R10) two-channel scan returns channel zero then channel one, alternating
// (R11) mode 110b: host starts first conversion, oscillator paces the rest
// (R12) host clears crossing flags by writing 03h
// (R13) host should abort before changing mode or configuration
// (R14) fill mode 100b: store until crossing, keep last 16, stop
// (R15) pre-alert fill overwrites oldest entries beyond 16
// (R16) abort in pre/post fill stops sequence and storing
// (R17) fill mode 110b: store sixteen results after crossing, then halt
// (R18) fill mode 001b: start fills buffer, halts when full
// (R19) fill mode 000b: fill continuously until abort, overwrite oldest
// (R20) mode 111b: start accumulates, stops after 16 or abort
// (R21) one accumulator per channel sums sixteen 12-bit results
// (R22) abort before busy falls leaves accumulations invalid
// (R23) high precision: data reads over i2c return zeros
// (R24) after reset: manual mode, dual-channel, channel zero first
// (R25) busy high during accumulation, low when all channels done
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_mode_sequencer (
  input wire logic clk, // 40 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  output logic [31:0] hrdata, // ahb read data
  input wire logic i2c_addr_rd, // device address with read bit seen
  input wire logic i2c_next, // host clocked out a sample
  input wire logic i2c_nack_stop, // nack then stop seen
  input wire logic i2c_reg_rd, // register read command seen
  output logic [11:0] i2c_sample, // result for the i2c shifter
  input wire logic scl_in, // scl pin level
  output logic scl_out, // scl drive level
  output logic scl_oe, // scl pulled low while high
  output logic conv_start, // converter start strobe
  output logic conv_ch, // channel of that conversion
  input wire logic conv_done, // converter result strobe
  input wire logic [11:0] conv_data, // converter result
  output logic osc_low, // use slow oscillator
  output logic [7:0] clk_div, // conversion clock divider
  input wire logic [1:0] cross_lo, // low crossing per channel
  input wire logic [1:0] cross_hi, // high crossing per channel
  output logic busy_rdy // high while accumulating
);
  adc_seq_pkg::seq_state_t state_q, state_d;
  logic [2:0] mode_q, bufm_q;
  logic [1:0] scan_q, accumulator_enable_q, flo_q, fhi_q;
  logic osc_q, armed_q, post_q, pend_q, chan_q, acc_ok_q;
  logic [7:0] div_q, div_cnt_q, low_cnt_q;
  logic [15:0] acc0_q, acc1_q;
  logic [4:0] cnt0_q, cnt1_q;
  logic [11:0] smp_q;
  logic scl_s1_q, scl_s2_q, wr_q, conv_go_q, conv_ch_q;
  logic [7:0] wa_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  store_if sif ();

  function automatic logic [15:0] acc_add(input logic [15:0] a,
                                          input logic [11:0] d);
    acc_add = a + {4'h0, d};
  endfunction : acc_add

  sample_store u_store (.clk(clk), .rstn(rstn), .sif(sif));

  // mode decode
  wire is_man1 = (mode_q == `M_MAN_A) || (mode_q == `M_MAN_B); // R01
  wire is_scan = (mode_q == `M_SCAN_A) || (mode_q == `M_SCAN_B); // R04
  wire is_auto = (mode_q == `M_AUTO); // R11
  wire is_prec = (mode_q == `M_PREC); // R20
  wire is_man = is_man1 || is_scan;
  wire in_idle = (state_q == adc_seq_pkg::st_idle);
  wire in_man = (state_q == adc_seq_pkg::st_man);
  wire in_auto = (state_q == adc_seq_pkg::st_auto);
  wire in_prec = (state_q == adc_seq_pkg::st_prec);
  wire in_halt = (state_q == adc_seq_pkg::st_halt);
  wire can_start = in_idle || in_halt;

  // bus decode
  wire addr_ph = hsel && htrans[1] && hready;
  wire wr_a = wr_q && (wa_q == `A_SEQ);
  wire start_p = wr_a && hwdata[`SEQUENCE_START_BIT_BIT];
  wire abort_p = wr_a && hwdata[`SEQUENCE_ABORT_BIT_BIT];
  wire [1:0] flag_clr_lo = (wr_q && wa_q == `A_FLO) ? hwdata[1:0] : 2'h0;
  wire [1:0] flag_clr_hi = (wr_q && wa_q == `A_FHI) ? hwdata[1:0] : 2'h0;

  // channel plan, power-up plan scans both from channel zero
  wire [1:0] scan_eff = (scan_q == 2'h0) ? 2'h1 : scan_q; // R24
  wire both_ch = (scan_eff == 2'h3) && !is_man1; // R10
  wire first_ch = (scan_eff == 2'h2) && !is_man1; // R01
  wire alert = |((flo_q | fhi_q) & scan_eff); // R14
  wire full = sif.full;

  // conversion starts: i2c paced in manual, divider paced otherwise
  wire man_entry = can_start && i2c_addr_rd &&
                   (is_man1 || (is_scan && armed_q)); // R02 R04
  wire man_go = man_entry ||
                (in_man && (i2c_next || i2c_addr_rd)); // R02
  wire run_start = can_start && start_p && (is_auto || is_prec); // R11 R20
  wire tick = (div_cnt_q == div_q);
  // no paced start in the cycle that leaves the run, so a full or
  // finished run never launches one conversion too many
  wire run_go = (in_auto || in_prec) && tick && !pend_q &&
                (state_d == state_q); // R11 R18
  wire go = man_go || run_start || run_go;

  // buffer rules per fill mode
  wire store_ok = (bufm_q != `BF_POST) || post_q; // R17
  wire auto_stop = ((bufm_q == `BF_PRE) && alert) || // R14
                   ((bufm_q == `BF_POST) && post_q && full) || // R17
                   ((bufm_q == `BF_START) && full); // R18
  assign sif.wr_en = in_auto && conv_done && store_ok; // R15 R19
  assign sif.wr_data = conv_data;
  assign sif.clr = run_start && is_auto;
  assign sif.rd_idx = haddr[5:2];

  // accumulation end: every scanned channel holds sixteen sums
  wire acc_done = (!scan_eff[0] || cnt0_q == `ACC_RUNS) &&
                  (!scan_eff[1] || cnt1_q == `ACC_RUNS); // R21 R25

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adc_seq_pkg::st_idle, adc_seq_pkg::st_halt: begin
        if (abort_p) state_d = adc_seq_pkg::st_idle;
        else if (man_entry) state_d = adc_seq_pkg::st_man;
        else if (run_start && is_auto) state_d = adc_seq_pkg::st_auto;
        else if (run_start) state_d = adc_seq_pkg::st_prec;
      end
      adc_seq_pkg::st_man: begin
        if (i2c_nack_stop) state_d = adc_seq_pkg::st_idle; // R03
        else if (is_scan && (abort_p || i2c_reg_rd))
          state_d = adc_seq_pkg::st_idle; // R05 R06
      end
      adc_seq_pkg::st_auto: begin
        if (abort_p) state_d = adc_seq_pkg::st_idle; // R16 R19
        else if (auto_stop) state_d = adc_seq_pkg::st_halt; // R14
      end
      adc_seq_pkg::st_prec: begin
        if (abort_p) state_d = adc_seq_pkg::st_idle; // R20 R22
        else if (acc_done) state_d = adc_seq_pkg::st_halt; // R20
      end
      default: state_d = adc_seq_pkg::st_idle;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_q <= adc_seq_pkg::st_idle; // R24
    else state_q <= state_d;
  end

  // scan arming: start bit arms, abort or register read disarms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) armed_q <= 1'h0;
    else if (abort_p || (is_scan && i2c_reg_rd)) armed_q <= 1'h0; // R06
    else if (start_p && is_scan) armed_q <= 1'h1; // R04
  end

  // oscillator pacing and pending conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 8'h00;
      pend_q <= 1'h0;
    end else begin
      div_cnt_q <= (tick || !(in_auto || in_prec)) ? 8'h00
                                                   : div_cnt_q + 8'h01;
      pend_q <= go || (pend_q && !conv_done);
    end
  end

  // start strobe and channel pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_go_q <= 1'h0;
      conv_ch_q <= 1'h0;
      chan_q <= 1'h0;
    end else begin
      conv_go_q <= go;
      if (go) conv_ch_q <= is_man1 ? 1'h0 : chan_q; // R01
      if (state_d == adc_seq_pkg::st_idle || run_start) chan_q <= first_ch;
      else if (conv_done && both_ch) chan_q <= !chan_q; // R10
    end
  end

  // post-alert arming
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) post_q <= 1'h0;
    else if (run_start || !in_auto) post_q <= 1'h0;
    else if (alert && bufm_q == `BF_POST) post_q <= 1'h1; // R17
  end

  // per-channel accumulators
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc0_q <= 16'h0000;
      acc1_q <= 16'h0000;
      cnt0_q <= 5'h00;
      cnt1_q <= 5'h00;
    end else if (run_start) begin
      acc0_q <= 16'h0000;
      acc1_q <= 16'h0000;
      cnt0_q <= 5'h00;
      cnt1_q <= 5'h00;
    end else if (in_prec && conv_done && !abort_p) begin // R20
      if (!conv_ch_q && cnt0_q != `ACC_RUNS) begin
        if (accumulator_enable_q[0]) acc0_q <= acc_add(acc0_q, conv_data); // R21
        cnt0_q <= cnt0_q + 5'h01;
      end
      if (conv_ch_q && cnt1_q != `ACC_RUNS) begin
        if (accumulator_enable_q[1]) acc1_q <= acc_add(acc1_q, conv_data); // R21
        cnt1_q <= cnt1_q + 5'h01;
      end
    end
  end

  // result validity follows a clean finish
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) acc_ok_q <= 1'h0;
    else if (run_start || abort_p) acc_ok_q <= 1'h0; // R22
    else if (in_prec && acc_done) acc_ok_q <= 1'h1; // R22
  end

  // i2c data path, zero in high precision
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) smp_q <= 12'h000;
    else if (is_prec) smp_q <= 12'h000; // R23
    else if (in_man && conv_done) smp_q <= conv_data; // R02 R10
  end

  // scl synchroniser and low-time counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1_q <= 1'h1;
      scl_s2_q <= 1'h1;
      low_cnt_q <= 8'h00;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      if (scl_s2_q) low_cnt_q <= 8'h00;
      else if (low_cnt_q != 8'(`STRETCH_CYC))
        low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // crossing flags: set wins over a write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flo_q <= 2'h0;
      fhi_q <= 2'h0;
    end else begin
      flo_q <= (flo_q & ~flag_clr_lo) | cross_lo; // R12
      fhi_q <= (fhi_q & ~flag_clr_hi) | cross_hi; // R12
    end
  end

  // ahb address phase capture and read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'h0;
      wa_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ph && hwrite;
      wa_q <= haddr[7:0];
      if (addr_ph && !hwrite) hrdata_q <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `MODE_RST; // R24
      bufm_q <= `BUFM_RST;
      scan_q <= `SCAN_RST; // R24
      osc_q <= 1'h0;
      div_q <= `DIV_RST;
      accumulator_enable_q <= 2'h0;
    end else if (wr_q) begin
      if (wa_q == `A_MODE) mode_q <= hwdata[2:0];
      if (wa_q == `A_BUFM) bufm_q <= hwdata[2:0];
      if (wa_q == `A_CFG) begin
        scan_q <= hwdata[1:0];
        osc_q <= hwdata[4];
        div_q <= hwdata[15:8];
        accumulator_enable_q <= hwdata[17:16];
      end
    end
  end

  // read selection, unmapped words read zero
  wire [31:0] stat_w = {17'h0_0000, acc_ok_q, full, sif.count,
                        busy_rdy, 2'h0, state_q};
  wire [31:0] cfg_w = {14'h0000, accumulator_enable_q, div_q, 3'h0, osc_q,
                       2'h0, scan_q};
  wire [7:0] ra = haddr[7:0];
  assign rd_mux =
    (ra[7:6] == `A_BUF_HI) ? {20'h0_0000, sif.rd_data} :
    (ra == `A_MODE) ? {29'h0000_0000, mode_q} :
    (ra == `A_SEQ) ? {30'h0000_0000, !in_idle, armed_q} :
    (ra == `A_BUFM) ? {29'h0000_0000, bufm_q} :
    (ra == `A_CFG) ? cfg_w :
    (ra == `A_STAT) ? stat_w :
    (ra == `A_ACC0) ? {16'h0000, acc0_q} :
    (ra == `A_ACC1) ? {16'h0000, acc1_q} :
    (ra == `A_FLO) ? {30'h0000_0000, flo_q} :
    (ra == `A_FHI) ? {30'h0000_0000, fhi_q} : 32'h0000_0000;

  // outputs
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign hrdata = hrdata_q;
  assign i2c_sample = smp_q;
  assign conv_start = conv_go_q;
  assign conv_ch = conv_ch_q;
  assign osc_low = osc_q && !is_man; // R07
  assign clk_div = is_man ? 8'h00 : div_q; // R07
  assign busy_rdy = in_prec; // R25
  assign scl_out = 1'h0;
  assign scl_oe = is_man && in_man && !scl_s2_q &&
                  (low_cnt_q < 8'(`STRETCH_CYC)); // R08 R09

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_single_read;
    can_start && is_man1 && i2c_addr_rd;
  endsequence
  sequence s_scan_abort;
    in_man && is_scan && i2c_reg_rd;
  endsequence
  sequence s_auto_abort;
    in_auto && abort_p;
  endsequence

  single_entry_a: assert property ( // R02
    s_single_read |=> in_man && conv_start)
    else $error("manual read did not start a conversion");
  nack_exit_a: assert property ( // R03
    in_man && is_man1 && i2c_nack_stop |=> in_idle)
    else $error("nack and stop did not end manual mode");
  reg_read_abort_a: assert property ( // R06
    s_scan_abort |=> in_idle && !armed_q)
    else $error("register read did not abort the scan");
  divider_ignored_a: assert property ( // R07
    is_man |-> clk_div == 8'h00 && !osc_low)
    else $error("divider reached converter in manual mode");
  stretch_release_a: assert property ( // R09
    $fell(scl_oe) && in_man && !scl_s2_q |-> low_cnt_q == 8'h48)
    else $error("scl released before 1.8 us low");
  channel_alternate_a: assert property ( // R10
    conv_done && both_ch && !in_idle && state_d != adc_seq_pkg::st_idle
    |=> chan_q != $past(chan_q))
    else $error("two-channel scan did not alternate");
  pre_alert_halt_a: assert property ( // R14
    in_auto && !abort_p && bufm_q == `BF_PRE && alert
    |=> in_halt && !sif.wr_en)
    else $error("pre-alert fill kept running after crossing");
  burst_full_a: assert property ( // R18
    in_auto && !abort_p && bufm_q == `BF_START && full |=> in_halt)
    else $error("start burst did not halt when full");
  abort_store_a: assert property ( // R16
    s_auto_abort |=> in_idle && !sif.wr_en)
    else $error("abort did not stop storing");
  prec_zero_a: assert property ( // R23
    is_prec ##1 is_prec |-> i2c_sample == 12'h000)
    else $error("high precision read returned data");
  busy_fall_a: assert property ( // R25
    in_prec && !abort_p && acc_done |=> !busy_rdy && acc_ok_q)
    else $error("busy did not fall on completed accumulation");
endmodule : adc_mode_sequencer

// ==== sim/conv_model.sv ====
// Purpose: converter model that answers each start strobe
// Assumes: one clock, starts are one-cycle pulses
// Notes: idle data line shows the inverse of its last value
`timescale 1ns/1ps
module conv_model (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic go, // conversion start
  input wire logic ch, // channel of that start
  input wire logic slow, // long conversion when high
  input wire logic [11:0] b0, // channel zero level
  input wire logic [11:0] b1, // channel one level
  output logic done, // result strobe
  output logic [11:0] dat // result
);
  logic [3:0] cnt_q;
  logic ch_q;
  // count down a pending conversion, scramble data outside the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      ch_q <= 1'b0;
      done <= 1'b0;
      dat <= 12'hA5A;
    end else begin
      done <= 1'b0;
      dat <= ~dat;
      if (go) begin
        cnt_q <= slow ? 4'h9 : 4'h1;
        ch_q <= ch;
      end else if (cnt_q == 4'h1) begin
        cnt_q <= 4'h0;
        done <= 1'b1;
        dat <= ch_q ? b1 : b0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : conv_model

// ==== sim/adc_mode_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the mode sequencer
// Assumes: converter model answers every start strobe
// Notes: bus reads queue their expectations, a monitor compares
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_mode_sequencer_tb_top;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_t;
  note_t q[$];
  note_t nt;
  logic chq[$];
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ev = 4'h0;
  logic [1:0] xlo = 2'h0;
  logic [1:0] xhi = 2'h0;
  logic scl_host = 1'b1;
  logic slow = 1'b0;
  logic [11:0] b0 = 12'h0;
  logic [11:0] b1 = 12'h0;
  logic hreadyout, hresp, scl_out, scl_oe, conv_start, conv_ch;
  logic conv_done, osc_low, busy_rdy, scl_w;
  logic [31:0] hrdata;
  logic [11:0] i2c_sample, conv_data;
  logic [7:0] clk_div;
  int fails = 0;
  int check_count = 0;
  int n_conv = 0;
  int k;
  always #12.5 clk = ~clk;
  // wired-and scl line, the device pulls it low while stretching
  assign scl_w = scl_host & ~scl_oe;
  adc_mode_sequencer DUT (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .i2c_addr_rd(ev[0]),
    .i2c_next(ev[1]), .i2c_nack_stop(ev[2]), .i2c_reg_rd(ev[3]),
    .i2c_sample(i2c_sample), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .conv_start(conv_start), .conv_ch(conv_ch),
    .conv_done(conv_done), .conv_data(conv_data), .osc_low(osc_low),
    .clk_div(clk_div), .cross_lo(xlo), .cross_hi(xhi),
    .busy_rdy(busy_rdy));
  conv_model conv (.clk(clk), .rstn(rstn), .go(conv_start),
    .ch(conv_ch), .slow(slow), .b0(b0), .b1(b1), .done(conv_done),
    .dat(conv_data));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // one single ahb transfer, held until hready is sampled high
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string nm);
    q.push_back('{nm, e & m, m});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk) ev[i] <= 1'b1;
    @(posedge clk) ev[i] <= 1'b0;
  endtask : pulse
  task automatic wdone();
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      if (conv_done === 1'b1) break;
    end
    @(negedge clk);
  endtask : wdone
  task automatic waitn(input int n);
    for (int i = 0; i < 4000 && n_conv < n; i++) @(negedge clk);
  endtask : waitn
  // count starts, compare channels and bus read data with the notes
  always @(negedge clk) begin
    if (conv_start === 1'b1) begin
      n_conv++;
      if (chq.size() > 0) chk("conv_ch", 32'(chq.pop_front()), 32'(conv_ch));
    end
  end
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      chk(nt.nm, nt.e, hrdata & nt.m);
      chk("hresp", 32'h0, 32'(hresp));
    end
  end
  // cut a hang short
  initial begin
    #500000;
    fails++;
    conclude();
  end
  // reset, manual, scan, autonomous fills, precision
  initial begin
    void'($urandom(76543));
    b0 = 12'($urandom());
    b1 = 12'($urandom());
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(`A_MODE, 32'(`MODE_RST), 32'h7, "mode");
    rd(`A_CFG, 32'(`SCAN_RST), 32'h3, "scan");
    rd(`A_STAT, 32'h1, 32'h1F, "state");
    wr(`A_CFG, 32'h0513);
    for (int m = 0; m < 2; m++) begin
      wr(`A_MODE, 32'(m));
      chq = '{1'b0, 1'b0};
      pulse(0);
      wdone();
      chk("sample", 32'(b0), 32'(i2c_sample));
      chk("clk_div", 32'h0, 32'(clk_div));
      chk("osc_low", 32'h0, 32'(osc_low));
      @(posedge clk) scl_host <= 1'b0;
      repeat (10) @(negedge clk);
      chk("stretch", 32'h1, 32'(scl_oe));
      repeat (80) @(negedge clk);
      chk("release", 32'h0, 32'(scl_oe));
      @(posedge clk) scl_host <= 1'b1;
      pulse(1);
      wdone();
      pulse(2);
      rd(`A_STAT, 32'h1, 32'h1F, "man_end");
    end
    for (int m = 4; m < 6; m++) begin
      wr(`A_MODE, 32'(m));
      wr(`A_SEQ, 32'h1);
      chq = '{1'b0, 1'b1, 1'b0};
      pulse(0);
      wdone();
      pulse(1);
      wdone();
      chk("sample", 32'(b1), 32'(i2c_sample));
      pulse(1);
      wdone();
      pulse(3);
      k = n_conv;
      pulse(1);
      repeat (20) @(negedge clk);
      chk("scan_abort", 32'(k), 32'(n_conv));
      wr(`A_SEQ, 32'h2);
      pulse(2);
    end
    wr(`A_MODE, 32'(`M_AUTO));
    wr(`A_CFG, 32'h0213);
    slow <= 1'b1;
    wr(`A_BUFM, 32'(`BF_STOP));
    k = n_conv;
    wr(`A_SEQ, 32'h1);
    waitn(k + 20);
    chk("auto_div", 32'h2, 32'(clk_div));
    chk("osc_auto", 32'h1, 32'(osc_low));
    rd(`A_STAT, 32'h3004, 32'h3F1F, "stop_fill");
    wr(`A_SEQ, 32'h2);
    slow <= 1'b0;
    repeat (30) @(negedge clk);
    k = n_conv;
    repeat (60) @(negedge clk);
    chk("stopped", 32'(k), 32'(n_conv));
    wr(`A_BUFM, 32'(`BF_START));
    k = n_conv;
    wr(`A_SEQ, 32'h1);
    waitn(k + 16);
    repeat (80) @(negedge clk);
    chk("burst_n", 32'(k + 16), 32'(n_conv));
    rd(`A_STAT, 32'h3010, 32'h3F1F, "burst_end");
    wr(`A_SEQ, 32'h2);
    wr(`A_BUFM, 32'(`BF_PRE));
    wr(`A_SEQ, 32'h1);
    waitn(n_conv + 20);
    @(posedge clk) xhi <= 2'h1;
    @(posedge clk) xhi <= 2'h0;
    repeat (40) @(negedge clk);
    k = n_conv;
    repeat (60) @(negedge clk);
    chk("pre_halt", 32'(k), 32'(n_conv));
    rd(`A_STAT, 32'h3010, 32'h3F1F, "pre_end");
    rd(`A_FHI, 32'h1, 32'h3, "hi_flag");
    wr(`A_FHI, 32'h3);
    rd(`A_FHI, 32'h0, 32'h3, "hi_clear");
    wr(`A_SEQ, 32'h2);
    wr(`A_BUFM, 32'(`BF_POST));
    for (int j = 0; j < 2; j++) begin
      wr(`A_FLO, 32'h3);
      wr(`A_SEQ, 32'h1);
      waitn(n_conv + 5);
      rd(`A_STAT, 32'h0004, 32'h3F1F, "post_wait");
      @(posedge clk) xlo <= 2'h2;
      @(posedge clk) xlo <= 2'h0;
      waitn(n_conv + ((j == 0) ? 5 : 17));
      if (j == 0) wr(`A_SEQ, 32'h2);
      repeat (80) @(negedge clk);
      if (j == 0) rd(`A_STAT, 32'h1, 32'h201F, "post_abort");
      else rd(`A_STAT, 32'h3010, 32'h3F1F, "post_end");
    end
    wr(`A_SEQ, 32'h2);
    wr(`A_MODE, 32'(`M_PREC));
    wr(`A_CFG, 32'h3_0203);
    wr(`A_SEQ, 32'h1);
    repeat (3) @(negedge clk);
    chk("busy", 32'h1, 32'(busy_rdy));
    for (int i = 0; i < 5000 && busy_rdy !== 1'b0; i++) @(negedge clk);
    pulse(0);
    repeat (5) @(negedge clk);
    chk("hp_sample", 32'h0, 32'(i2c_sample));
    rd(`A_ACC0, 32'(b0) * 16, 32'hFFFF, "acc0");
    rd(`A_ACC1, 32'(b1) * 16, 32'hFFFF, "acc1");
    rd(`A_STAT, 32'h4000, 32'h4080, "acc_ok");
    wr(`A_SEQ, 32'h1);
    repeat (10) @(negedge clk);
    wr(`A_SEQ, 32'h2);
    rd(`A_STAT, 32'h0, 32'h4080, "acc_bad");
    conclude();
  end
endmodule : adc_mode_sequencer_tb_top
